// [rtl/gsi_pkg.sv]
// gsi_pkg: command locations, subcommand codes, status word layout
// and reset values for the gauge subcommand interpreter.
// assumes: imported whole by gsi_core.
package gsi_pkg;

  // command locations on the serial bus
  localparam logic [7:0]  CMD_CTRL_LO    = 8'h00;
  localparam logic [7:0]  CMD_CTRL_HI    = 8'h01;
  localparam logic [7:0]  CMD_MAC_LO     = 8'h3E;
  localparam logic [7:0]  CMD_MAC_HI     = 8'h3F;
  localparam logic [7:0]  CMD_BUF_FIRST  = 8'h40;
  localparam logic [7:0]  CMD_BUF_LAST   = 8'h5F;
  localparam int          BUF_BYTES      = 32;
  localparam int          BUF_IDX_W      = 5;

  // subcommand codes
  localparam logic [15:0] SC_STATUS_NOP  = 16'h0000;
  localparam logic [15:0] SC_DEV_TYPE    = 16'h0001;
  localparam logic [15:0] SC_FW_REV      = 16'h0002;
  localparam logic [15:0] SC_HW_REV      = 16'h0003;
  localparam logic [15:0] SC_IMEM_SUM    = 16'h0004;
  localparam logic [15:0] SC_STATIC_SUM  = 16'h0005;
  localparam logic [15:0] SC_CHEMISTRY_IDENTIFIER_QUERY     = 16'h0006;
  localparam logic [15:0] SC_PREV_SC     = 16'h0007;
  localparam logic [15:0] SC_CHEM_SUM    = 16'h0008;
  localparam logic [15:0] SC_BOARD_OFS   = 16'h0009;
  localparam logic [15:0] SC_CTR_OFS     = 16'h000A;
  localparam logic [15:0] SC_OFS_STORE   = 16'h000B;
  localparam logic [15:0] SC_OCV_REQ     = 16'h000C;
  localparam logic [15:0] SC_FULL_SUM    = 16'h0010;
  localparam logic [15:0] SC_DEEP_SET    = 16'h0011;
  localparam logic [15:0] SC_DEEP_CLR    = 16'h0012;
  localparam logic [15:0] SC_LIGHT_SET   = 16'h0013;
  localparam logic [15:0] SC_LIGHT_CLR   = 16'h0014;
  localparam logic [15:0] SC_PROFILE0    = 16'h0015;
  localparam logic [15:0] SC_PROFILE3    = 16'h0018;
  localparam logic [15:0] SC_CAL_TOGGLE  = 16'h002D;
  localparam logic [15:0] SC_SEAL        = 16'h0030;
  localparam logic [15:0] SC_KEYS        = 16'h0035;
  localparam logic [15:0] SC_DEV_RESET   = 16'h0041;
  localparam logic [15:0] SC_DEV_NAME    = 16'h004A;
  localparam logic [15:0] SC_OP_STATUS   = 16'h0054;
  localparam logic [15:0] SC_GAUGE_STATE = 16'h0056;
  localparam logic [15:0] SC_MAKER_INFO  = 16'h0070;
  localparam logic [15:0] SC_DEBUG1      = 16'h0073;
  localparam logic [15:0] SC_DEBUG4      = 16'h0076;
  localparam logic [15:0] SC_CAL_EXIT    = 16'h0080;
  localparam logic [15:0] SC_CAL_ENTER   = 16'h0081;
  localparam logic [15:0] SC_ROM_RETURN  = 16'h0F00;
  localparam logic [15:0] CFG_WIN_LOW    = 16'h4000;
  localparam logic [15:0] CFG_WIN_HIGH   = 16'h43FF;

  // status word
  localparam logic [15:0] REDIRECT_MARK  = 16'hFFA5;
  localparam int          ST_DEEP_BIT    = 7;
  localparam int          ST_CCA_BIT     = 5;
  localparam int          ST_BCA_BIT     = 4;
  localparam int          ST_LIGHT_BIT   = 3;
  localparam logic [7:0]  STATUS_HI_RSVD = 8'h00;
  localparam logic [7:0]  UNMAPPED_BYTE  = 8'h00;

  // reset values
  localparam logic        RST_LOCKED     = 1'b0;
  localparam logic [1:0]  RST_PROFILE    = 2'h0;

endpackage

// [rtl/gsi_core.sv]
// gsi_core: subcommand interpreter behind the serial-bus slave of a
// battery gauge: control word, manufacturer access word, response
// buffer, status word, locked_access_mode/unsealed gating.
// assumes: the bus slave presents one byte access per request on the
// link clock; firmware on i_clk fills report data into the buffer.
`timescale 1ns/10ps
`default_nettype none

module gsi_core
  import gsi_pkg::*;
#(
  // arbitrary identity value
  parameter logic [15:0] DEV_TYPE_ID = 16'h0A5C
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_lnk_clk,
  input  wire logic        i_lnk_rst,
  input  wire logic        i_lnk_wr_stb,
  input  wire logic        i_lnk_rd_stb,
  input  wire logic [7:0]  i_lnk_addr,
  input  wire logic [7:0]  i_lnk_wdata,
  output logic             o_lnk_busy,
  output logic             o_lnk_rvalid,
  output logic [7:0]       o_lnk_rdata,
  input  wire logic        i_unseal_stb,
  input  wire logic        i_deep_sleep_exit,
  input  wire logic        i_cca_active,
  input  wire logic        i_bca_active,
  input  wire logic        i_fill_stb,
  input  wire logic [4:0]  i_fill_idx,
  input  wire logic [7:0]  i_fill_byte,
  output logic             o_locked,
  output logic             o_deep_sleep_req,
  output logic             o_light_sleep_en,
  output logic [1:0]       o_profile,
  output logic             o_cal_mode,
  output logic             o_cal_flag,
  output logic             o_board_ofs_stb,
  output logic             o_ctr_ofs_stb,
  output logic             o_ofs_store_stb,
  output logic             o_ocv_req_stb,
  output logic             o_dev_reset_stb,
  output logic             o_rom_return_stb,
  output logic             o_fetch_stb,
  output logic [15:0]      o_fetch_code,
  output logic             o_buf_wr_stb,
  output logic [4:0]       o_buf_wr_idx
);

  // subcommands refused while locked
  function automatic logic unsealed_only(input logic [15:0] code);
    unsealed_only = (code == SC_CAL_TOGGLE) || (code == SC_SEAL) ||
                    (code == SC_KEYS) || (code == SC_DEV_RESET) ||
                    (code == SC_CAL_EXIT) || (code == SC_CAL_ENTER) ||
                    (code == SC_ROM_RETURN) ||
                    ((code >= CFG_WIN_LOW) && (code <= CFG_WIN_HIGH));
  endfunction

  // subcommands whose data firmware must place in the buffer
  function automatic logic needs_fetch(input logic [15:0] code);
    needs_fetch = ((code >= SC_FW_REV) && (code <= SC_CHEMISTRY_IDENTIFIER_QUERY)) ||
                  (code == SC_CHEM_SUM) || (code == SC_FULL_SUM) ||
                  (code == SC_KEYS) || (code == SC_DEV_NAME) ||
                  (code == SC_OP_STATUS) || (code == SC_GAUGE_STATE) ||
                  (code == SC_MAKER_INFO) ||
                  ((code >= SC_DEBUG1) && (code <= SC_DEBUG4)) ||
                  ((code >= CFG_WIN_LOW) && (code <= CFG_WIN_HIGH));
  endfunction

  // ---------------- link domain ----------------
  logic       lnk_req_tgl_r;
  logic       lnk_wr_r;
  logic [7:0] lnk_addr_r;
  logic [7:0] lnk_wdata_r;
  logic       lnk_ack_s1_r;
  logic       lnk_ack_s2_r;
  logic       lnk_ack_seen_r;
  logic       lnk_ack_new;

  // core domain signals seen by the link side
  logic       ack_tgl_r;
  logic [7:0] rdata_r;

  assign lnk_ack_new = lnk_ack_s2_r ^ lnk_ack_seen_r;

  always_ff @(posedge i_lnk_clk) begin
    if (i_lnk_rst) begin
      lnk_ack_s1_r <= 1'b0;
      lnk_ack_s2_r <= 1'b0;
    end else begin
      lnk_ack_s1_r <= ack_tgl_r;
      lnk_ack_s2_r <= lnk_ack_s1_r;
    end
  end

  // one byte access in flight; capture held stable until the answer
  always_ff @(posedge i_lnk_clk) begin
    if (i_lnk_rst) begin
      lnk_req_tgl_r  <= 1'b0;
      lnk_wr_r       <= 1'b0;
      lnk_addr_r     <= 8'h00;
      lnk_wdata_r    <= 8'h00;
      lnk_ack_seen_r <= 1'b0;
      o_lnk_busy     <= 1'b0;
      o_lnk_rvalid   <= 1'b0;
      o_lnk_rdata    <= 8'h00;
    end else begin
      o_lnk_rvalid <= 1'b0;
      if (!o_lnk_busy && (i_lnk_wr_stb || i_lnk_rd_stb)) begin
        lnk_req_tgl_r <= ~lnk_req_tgl_r;
        lnk_wr_r      <= i_lnk_wr_stb;
        lnk_addr_r    <= i_lnk_addr;
        lnk_wdata_r   <= i_lnk_wdata;
        o_lnk_busy    <= 1'b1;
      end else if (o_lnk_busy && lnk_ack_new) begin
        lnk_ack_seen_r <= lnk_ack_s2_r;
        o_lnk_busy     <= 1'b0;
        o_lnk_rvalid   <= ~lnk_wr_r;
        o_lnk_rdata    <= rdata_r;
      end
    end
  end

  // ---------------- core domain ----------------
  logic        req_s1_r;
  logic        req_s2_r;
  logic        req_seen_r;
  logic        req_fire;
  logic        wr_fire;
  logic        rd_fire;
  logic        exec;
  logic        go;
  logic [15:0] code;
  logic        buf_sel;
  logic        mac_wr_lo;
  logic [7:0]  mac_lo_r;
  logic [7:0]  mac_hi_r;
  logic [15:0] last_code_r;
  logic        redirect_r;
  logic        bca_r;
  logic        cca_r;
  logic [7:0]  status_lo;
  logic [7:0]  rsp_buf [BUF_BYTES];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
    end else begin
      req_s1_r   <= lnk_req_tgl_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_s2_r;
    end
  end

  assign req_fire  = req_s2_r ^ req_seen_r;
  assign wr_fire   = req_fire && lnk_wr_r;
  assign rd_fire   = req_fire && !lnk_wr_r;
  assign buf_sel   = (lnk_addr_r >= CMD_BUF_FIRST) &&
                     (lnk_addr_r <= CMD_BUF_LAST);
  assign mac_wr_lo = wr_fire && ((lnk_addr_r == CMD_CTRL_LO) ||
                                 (lnk_addr_r == CMD_MAC_LO));
  // high byte completes the subcommand, low byte taken first
  assign exec = wr_fire && ((lnk_addr_r == CMD_CTRL_HI) ||
                            (lnk_addr_r == CMD_MAC_HI));
  assign code = {lnk_wdata_r, mac_lo_r};
  assign go   = exec && !(o_locked && unsealed_only(code));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mac_lo_r <= 8'h00;
      mac_hi_r <= 8'h00;
    end else if (mac_wr_lo) begin
      mac_lo_r <= lnk_wdata_r;
    end else if (exec) begin
      mac_hi_r <= lnk_wdata_r;
    end
  end

  // refused seal leaves the lock alone; falls out of the gating
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_locked <= RST_LOCKED;
    end else if (go && (code == SC_SEAL)) begin
      o_locked <= 1'b1;
    end else if (i_unseal_stb) begin
      o_locked <= 1'b0;
    end
  end

  // set wins over any clear arriving in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_deep_sleep_req <= 1'b0;
    end else if (go && (code == SC_DEEP_SET)) begin
      o_deep_sleep_req <= 1'b1;
    end else if ((go && (code == SC_DEEP_CLR)) || i_deep_sleep_exit) begin
      o_deep_sleep_req <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_light_sleep_en <= 1'b0;
    end else if (go && (code == SC_LIGHT_SET)) begin
      o_light_sleep_en <= 1'b1;
    end else if (go && (code == SC_LIGHT_CLR)) begin
      o_light_sleep_en <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_profile <= RST_PROFILE;
    end else if (go && (code >= SC_PROFILE0) && (code <= SC_PROFILE3)) begin
      o_profile <= code[1:0] - SC_PROFILE0[1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cal_mode <= 1'b0;
      o_cal_flag <= 1'b0;
    end else if (go) begin
      if (code == SC_CAL_ENTER) begin
        o_cal_mode <= 1'b1;
      end else if (code == SC_CAL_EXIT) begin
        o_cal_mode <= 1'b0;
      end
      if (code == SC_CAL_TOGGLE) begin
        o_cal_flag <= ~o_cal_flag;
      end
    end
  end

  // one-cycle action strobes toward the gauging firmware
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_board_ofs_stb  <= 1'b0;
      o_ctr_ofs_stb    <= 1'b0;
      o_ofs_store_stb  <= 1'b0;
      o_ocv_req_stb    <= 1'b0;
      o_dev_reset_stb  <= 1'b0;
      o_rom_return_stb <= 1'b0;
      o_fetch_stb      <= 1'b0;
      o_fetch_code     <= SC_STATUS_NOP;
    end else begin
      o_board_ofs_stb  <= go && (code == SC_BOARD_OFS);
      o_ctr_ofs_stb    <= go && (code == SC_CTR_OFS);
      o_ofs_store_stb  <= go && (code == SC_OFS_STORE);
      o_ocv_req_stb    <= go && (code == SC_OCV_REQ);
      o_dev_reset_stb  <= go && (code == SC_DEV_RESET);
      o_rom_return_stb <= go && (code == SC_ROM_RETURN);
      o_fetch_stb      <= go && needs_fetch(code);
      if (go && needs_fetch(code)) begin
        o_fetch_code <= code;
      end
    end
  end

  // code zero updates nothing here either
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_code_r <= SC_STATUS_NOP;
    end else if (go && (code != SC_STATUS_NOP)) begin
      last_code_r <= code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      redirect_r <= 1'b0;
    end else if (go && ((code == SC_DEV_TYPE) || (code == SC_FW_REV))) begin
      redirect_r <= 1'b1;
    end else if (rd_fire && (lnk_addr_r == CMD_CTRL_HI)) begin
      redirect_r <= 1'b0;
    end
  end

  // shared response buffer; host writes only while unlocked
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        rsp_buf[i] <= 8'h00;
      end
    end else if (go && (code == SC_DEV_TYPE)) begin
      rsp_buf[0] <= DEV_TYPE_ID[7:0];
      rsp_buf[1] <= DEV_TYPE_ID[15:8];
    end else if (go && (code == SC_PREV_SC)) begin
      rsp_buf[0] <= last_code_r[7:0];
      rsp_buf[1] <= last_code_r[15:8];
    end else if (wr_fire && buf_sel && !o_locked) begin
      rsp_buf[lnk_addr_r[BUF_IDX_W-1:0]] <= lnk_wdata_r;
    end else if (i_fill_stb) begin
      rsp_buf[i_fill_idx] <= i_fill_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_buf_wr_stb <= 1'b0;
      o_buf_wr_idx <= 5'h00;
    end else begin
      o_buf_wr_stb <= wr_fire && buf_sel && !o_locked;
      if (wr_fire && buf_sel) begin
        o_buf_wr_idx <= lnk_addr_r[BUF_IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cca_r <= 1'b0;
      bca_r <= 1'b0;
    end else begin
      cca_r <= i_cca_active;
      bca_r <= i_bca_active;
    end
  end

  always_comb begin
    status_lo               = 8'h00;
    status_lo[ST_DEEP_BIT]  = o_deep_sleep_req;
    status_lo[ST_CCA_BIT]   = cca_r;
    status_lo[ST_BCA_BIT]   = bca_r;
    status_lo[ST_LIGHT_BIT] = o_light_sleep_en;
    status_lo[1:0]          = o_profile;
  end

  // read answer; rdata_r stays put while the link copies it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (rd_fire) begin
      if (lnk_addr_r == CMD_CTRL_LO) begin
        rdata_r <= redirect_r ? REDIRECT_MARK[7:0] : status_lo;
      end else if (lnk_addr_r == CMD_CTRL_HI) begin
        rdata_r <= redirect_r ? REDIRECT_MARK[15:8] : STATUS_HI_RSVD;
      end else if (lnk_addr_r == CMD_MAC_LO) begin
        rdata_r <= mac_lo_r;
      end else if (lnk_addr_r == CMD_MAC_HI) begin
        rdata_r <= mac_hi_r;
      end else if (buf_sel) begin
        rdata_r <= rsp_buf[lnk_addr_r[BUF_IDX_W-1:0]];
      end else begin
        rdata_r <= UNMAPPED_BYTE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_tgl_r <= 1'b0;
    end else if (req_fire) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

endmodule

`default_nettype wire

// [verification/gsi_core_props.sv]
// gsi_core_props: port-level assertions for gsi_core.
// assumes: bound to every gsi_core instance, both clocks running.
`timescale 1ns/10ps
`default_nettype none
module gsi_core_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lnk_clk,
  input wire logic i_lnk_rst,
  input wire logic i_lnk_wr_stb,
  input wire logic i_lnk_rd_stb,
  input wire logic o_lnk_busy,
  input wire logic o_lnk_rvalid,
  input wire logic i_unseal_stb,
  input wire logic o_locked,
  input wire logic o_cal_mode,
  input wire logic o_cal_flag,
  input wire logic o_board_ofs_stb,
  input wire logic o_dev_reset_stb,
  input wire logic o_rom_return_stb
);
  sequence take_s;
    (i_lnk_wr_stb || i_lnk_rd_stb) && !o_lnk_busy;
  endsequence
  sequence answer_s;
    o_lnk_busy ##[1:60] !o_lnk_busy;
  endsequence
  busy_take_a: assert property (@(posedge i_lnk_clk)
    disable iff (i_lnk_rst) take_s |=> o_lnk_busy)
    else $error("link request not taken");
  busy_bound_a: assert property (@(posedge i_lnk_clk)
    disable iff (i_lnk_rst) take_s |=> answer_s)
    else $error("link answer late");
  rvalid_pulse_a: assert property (@(posedge i_lnk_clk)
    disable iff (i_lnk_rst) o_lnk_rvalid |-> !o_lnk_busy ##1 !o_lnk_rvalid)
    else $error("read answer malformed");
  lock_clear_a: assert property (@(posedge i_clk)
    disable iff (i_rst) $fell(o_locked) |-> $past(i_unseal_stb))
    else $error("lock cleared without unseal");
  cal_gate_a: assert property (@(posedge i_clk)
    disable iff (i_rst) $changed(o_cal_mode) |-> !$past(o_locked))
    else $error("calibration mode changed while locked");
  flag_gate_a: assert property (@(posedge i_clk)
    disable iff (i_rst) $changed(o_cal_flag) |-> !$past(o_locked))
    else $error("calibration flag changed while locked");
  reset_gate_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    o_dev_reset_stb |-> !$past(o_locked) ##1 !o_dev_reset_stb)
    else $error("device reset pulse wrong");
  rom_gate_a: assert property (@(posedge i_clk)
    disable iff (i_rst) o_rom_return_stb |-> !$past(o_locked))
    else $error("boot rom return while locked");
  ofs_pulse_a: assert property (@(posedge i_clk)
    disable iff (i_rst) o_board_ofs_stb |=> !o_board_ofs_stb)
    else $error("board offset strobe too long");
endmodule
bind gsi_core gsi_core_props i_gsi_core_props (.*);
`default_nettype wire

// [verification/gsi_host.sv]
// gsi_host: byte-access master on the link side of gsi_core.
// assumes: the bench calls xfer only while no other xfer runs.
`timescale 1ns/10ps
`default_nettype none
module gsi_host (
  input  wire logic       i_lnk_clk,
  input  wire logic       i_busy,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output var logic        o_wr_stb,
  output var logic        o_rd_stb,
  output var logic [7:0]  o_addr,
  output var logic [7:0]  o_wdata,
  output var logic        o_err
);
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'hFF;
    o_wdata = 8'hFF;
    o_err = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    int n;
    @(posedge i_lnk_clk);
    o_wr_stb <= w;
    o_rd_stb <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_lnk_clk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b0;
    // released lines show the inverse of the last value
    o_addr <= ~a;
    o_wdata <= ~d;
    n = 0;
    do begin
      @(posedge i_lnk_clk);
      #1 n++;
    end while (i_busy !== 1'b0 && n < 60);
    q = i_rdata;
    if (n >= 60 || (!w && i_rvalid !== 1'b1))
      o_err = 1'b1;
  endtask
endmodule
`default_nettype wire

// [verification/test_gsi_core.sv]
// test_gsi_core: self-checking bench for gsi_core.
// assumes: gsi_host drives the link, bench drives the core side.
`timescale 1ns/10ps
`default_nettype none
module test_gsi_core;
  import gsi_pkg::*;
  // arbitrary identity value
  localparam logic [15:0] ID = 16'h1B2C;
  logic i_clk, i_rst, i_lnk_clk, i_lnk_rst, i_lnk_wr_stb, i_lnk_rd_stb;
  logic [7:0] i_lnk_addr, i_lnk_wdata, o_lnk_rdata, i_fill_byte, q;
  logic o_lnk_busy, o_lnk_rvalid, i_unseal_stb, i_deep_sleep_exit;
  logic i_cca_active, i_bca_active, i_fill_stb, o_locked, o_cal_flag;
  logic o_deep_sleep_req, o_light_sleep_en, o_cal_mode, o_fetch_stb;
  logic o_board_ofs_stb, o_ctr_ofs_stb, o_ofs_store_stb, o_ocv_req_stb;
  logic o_dev_reset_stb, o_rom_return_stb, o_buf_wr_stb, err;
  logic [4:0] i_fill_idx, o_buf_wr_idx;
  logic [1:0] o_profile;
  logic [15:0] o_fetch_code, w;
  logic [7:0] seen;
  int fail_count, num_checks, k;
  logic [15:0] fc [14] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0008, 16'h0010, 16'h004A, 16'h0054, 16'h0056, 16'h0070,
    16'h0073, 16'h0074, 16'h0075, 16'h0076};
  logic [15:0] rf [7] = '{16'h0030, 16'h0081, 16'h002D, 16'h0035,
    16'h0041, 16'h0F00, 16'h4000};

  gsi_core #(.DEV_TYPE_ID(ID)) i_gsi_core (.*);
  gsi_host i_gsi_host (.i_lnk_clk(i_lnk_clk), .i_busy(o_lnk_busy),
    .i_rvalid(o_lnk_rvalid), .i_rdata(o_lnk_rdata),
    .o_wr_stb(i_lnk_wr_stb), .o_rd_stb(i_lnk_rd_stb),
    .o_addr(i_lnk_addr), .o_wdata(i_lnk_wdata), .o_err(err));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    i_lnk_clk = 1'b0;
    // odd offset keeps link edges off the core clock edges
    #7.3;
    forever #3 i_lnk_clk = ~i_lnk_clk;
  end
  // sticky record of the one-cycle core pulses
  always @(posedge i_clk)
    seen <= seen | {o_buf_wr_stb, o_fetch_stb, o_rom_return_stb,
      o_dev_reset_stb, o_ocv_req_stb, o_ofs_store_stb, o_ctr_ofs_stb,
      o_board_ofs_stb};

  task automatic chk(input string nm, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic sc(input logic [7:0] a, input logic [15:0] c);
    #1 seen = 8'h00;
    i_gsi_host.xfer(1'b1, a, c[7:0], q);
    i_gsi_host.xfer(1'b1, a + 8'h01, c[15:8], q);
    repeat (3) @(posedge i_clk);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    i_gsi_host.xfer(1'b0, a, 8'h00, v[7:0]);
    i_gsi_host.xfer(1'b0, a + 8'h01, 8'h00, v[15:8]);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    test_done;
  end

  initial begin
    {i_rst, i_lnk_rst, seen} = {2'b11, 8'h00};
    {i_unseal_stb, i_deep_sleep_exit, i_cca_active, i_bca_active} = 4'h0;
    {i_fill_stb, i_fill_idx, i_fill_byte} = 14'h0000;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_lnk_clk) i_lnk_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd16(CMD_CTRL_LO, w);
    chk("status", w, 16'h0000);
    for (k = 0; k < 4; k++) begin
      sc(k[0] ? CMD_MAC_LO : CMD_CTRL_LO, SC_PROFILE0 + k[15:0]);
      rd16(CMD_CTRL_LO, w);
      chk("profile", w, k[15:0]);
      chk("profile out", o_profile, k[15:0]);
    end
    sc(CMD_MAC_LO, SC_DEEP_SET);
    sc(CMD_CTRL_LO, SC_LIGHT_SET);
    rd16(CMD_CTRL_LO, w);
    chk("sleep set", w, 16'h008B);
    chk("sleep out", {o_deep_sleep_req, o_light_sleep_en}, 2'b11);
    @(posedge i_clk) {i_cca_active, i_bca_active} <= 2'b11;
    rd16(CMD_CTRL_LO, w);
    chk("cal bits", w, 16'h00BB);
    @(posedge i_clk) {i_cca_active, i_bca_active, i_deep_sleep_exit} <= 3'b001;
    @(posedge i_clk) i_deep_sleep_exit <= 1'b0;
    @(posedge i_clk) chk("sleep exit", o_deep_sleep_req, 1'b0);
    sc(CMD_CTRL_LO, SC_DEEP_CLR);
    sc(CMD_MAC_LO, SC_LIGHT_CLR);
    rd16(CMD_CTRL_LO, w);
    chk("sleep clr", w, 16'h0003);
    chk("sleep off", {o_deep_sleep_req, o_light_sleep_en}, 2'b00);
    sc(CMD_CTRL_LO, SC_DEV_TYPE);
    rd16(CMD_CTRL_LO, w);
    chk("marker", w, REDIRECT_MARK);
    rd16(CMD_CTRL_LO, w);
    chk("status", w, 16'h0003);
    rd16(CMD_MAC_LO, w);
    chk("echo", w, SC_DEV_TYPE);
    rd16(CMD_BUF_FIRST, w);
    chk("dev type", w, ID);
    sc(CMD_MAC_LO, SC_FW_REV);
    rd16(CMD_CTRL_LO, w);
    chk("fw marker", w, REDIRECT_MARK);
    sc(CMD_CTRL_LO, SC_STATUS_NOP);
    rd16(CMD_CTRL_LO, w);
    chk("nop", w, 16'h0003);
    sc(CMD_CTRL_LO, SC_PREV_SC);
    rd16(CMD_BUF_FIRST, w);
    chk("previous", w, SC_FW_REV);
    for (k = 0; k < 4; k++) begin
      sc(CMD_CTRL_LO, SC_BOARD_OFS + k[15:0]);
      chk("strobe", {8'h00, seen}, 16'h0001 << k);
    end
    for (k = 0; k < 14; k++) begin
      sc(CMD_MAC_LO, fc[k]);
      chk("fetch", {seen[6], o_fetch_code[14:0]}, fc[k] | 16'h8000);
    end
    @(posedge i_clk) {i_fill_stb, i_fill_idx, i_fill_byte} <= 14'h225A;
    @(posedge i_clk) i_fill_stb <= 1'b0;
    i_gsi_host.xfer(1'b0, 8'h42, 8'h00, q);
    chk("fill", {8'h00, q}, 16'h005A);
    #1 seen = 8'h00;
    i_gsi_host.xfer(1'b1, 8'h44, 8'hC3, q);
    repeat (3) @(posedge i_clk);
    chk("host wr", {seen[7], o_buf_wr_idx}, 6'h24);
    sc(CMD_CTRL_LO, SC_CAL_ENTER);
    chk("cal on", o_cal_mode, 1'b1);
    sc(CMD_CTRL_LO, SC_CAL_EXIT);
    sc(CMD_CTRL_LO, SC_CAL_TOGGLE);
    chk("cal", {o_cal_mode, o_cal_flag}, 2'b01);
    sc(CMD_MAC_LO, SC_SEAL);
    chk("locked", o_locked, 1'b1);
    for (k = 0; k < 7; k++) begin
      sc(CMD_MAC_LO, rf[k]);
      chk("refused", {8'h00, seen}, 16'h0000);
    end
    chk("locked st", {o_locked, o_cal_mode, o_cal_flag}, 3'b101);
    i_gsi_host.xfer(1'b1, 8'h44, 8'h3C, q);
    i_gsi_host.xfer(1'b0, 8'h44, 8'h00, q);
    chk("locked buf", {8'h00, q}, 16'h00C3);
    sc(CMD_CTRL_LO, SC_PROFILE0 + 16'h0001);
    rd16(CMD_CTRL_LO, w);
    chk("locked_access_mode ok", w, 16'h0001);
    @(posedge i_clk) i_unseal_stb <= 1'b1;
    @(posedge i_clk) i_unseal_stb <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("unlocked", o_locked, 1'b0);
    sc(CMD_CTRL_LO, SC_DEV_RESET);
    chk("dev reset", seen[4], 1'b1);
    sc(CMD_CTRL_LO, SC_ROM_RETURN);
    chk("rom", seen[5], 1'b1);
    sc(CMD_MAC_LO, CFG_WIN_HIGH);
    chk("cfg win", o_fetch_code, CFG_WIN_HIGH);
    chk("host", err, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
